// ==== timer_io_control.sv ====
// timer I/O control: io control registers, mode and run bits, and the
// per-general-register pin logic (compare output and capture edge detect)
// assumes the counter outside supplies compare-match and clear pulses on
// i_clk, and that pins are asynchronous to i_clk

module timer_io_control
   import tio_pkg::*;
(
   input wire logic i_clk, // 100 MHz peripheral clock
   input wire logic i_srst, // synchronous reset, active high
   input wire logic [ADDR_W-1:0] i_addr, // register address
   input wire logic [DATA_W-1:0] i_wdata, // register write data
   input wire logic i_wr, // write strobe
   input wire logic i_rd, // read strobe
   output logic [DATA_W-1:0] o_rdata, // read data, cycle after i_rd
   input wire logic [NUM_GR-1:0] i_cmp_match, // compare match per register
   input wire logic [NUM_CH-1:0] i_ctr_clear, // counter cleared per channel
   output logic [NUM_CH-1:0] o_run, // counter run bits
   output logic [NUM_GR-1:0] o_capture, // capture event pulses
   input wire logic [NUM_GR-1:0] i_pin, // pin levels, asynchronous
   output logic [NUM_GR-1:0] o_pin, // pin drive levels
   output logic [NUM_GR-1:0] o_pin_oe // pin output enables
);

   // -----------------------------------------------------------------
   // register access decode
   // -----------------------------------------------------------------
   // true when a strobe addresses the given register
   function automatic logic hit(
      input logic strobe,
      input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] target
   );
      return strobe && (addr == target);
   endfunction

   // mode write value: read-only ones forced, buffer bits kept only
   // where the channel has C and D registers to pair with
   function automatic logic [DATA_W-1:0] mode_value(
      input logic [DATA_W-1:0] wdata,
      input logic has_buffers
   );
      logic [DATA_W-1:0] m;
      m = wdata | MODE_FIXED_ONES;
      if (!has_buffers) begin
         m[BFB_BIT:BFA_BIT] = MODE_BUF_NONE;
      end
      return m;
   endfunction

   // -----------------------------------------------------------------
   // io control registers
   // -----------------------------------------------------------------
   logic [DATA_W-1:0] io_ctrl_ch0_high;
   logic [DATA_W-1:0] io_ctrl_ch0_low;
   logic [DATA_W-1:0] io_ctrl_ch1;
   logic [DATA_W-1:0] io_ctrl_ch2;
   logic [DATA_W-1:0] next_io_ctrl_ch0_high;
   logic [DATA_W-1:0] next_io_ctrl_ch0_low;
   logic [DATA_W-1:0] next_io_ctrl_ch1;
   logic [DATA_W-1:0] next_io_ctrl_ch2;

   always_comb begin
      next_io_ctrl_ch0_high = io_ctrl_ch0_high;
      next_io_ctrl_ch0_low = io_ctrl_ch0_low;
      next_io_ctrl_ch1 = io_ctrl_ch1;
      next_io_ctrl_ch2 = io_ctrl_ch2;
      if (hit(i_wr, i_addr, ADDR_IO_CH0_HIGH)) begin
         next_io_ctrl_ch0_high = i_wdata;
      end
      if (hit(i_wr, i_addr, ADDR_IO_CH0_LOW)) begin
         next_io_ctrl_ch0_low = i_wdata;
      end
      if (hit(i_wr, i_addr, ADDR_IO_CH1)) begin
         next_io_ctrl_ch1 = i_wdata;
      end
      if (hit(i_wr, i_addr, ADDR_IO_CH2)) begin
         next_io_ctrl_ch2 = i_wdata;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         io_ctrl_ch0_high <= REG_RESET;
         io_ctrl_ch0_low <= REG_RESET;
         io_ctrl_ch1 <= REG_RESET;
         io_ctrl_ch2 <= REG_RESET;
      end else begin
         io_ctrl_ch0_high <= next_io_ctrl_ch0_high;
         io_ctrl_ch0_low <= next_io_ctrl_ch0_low;
         io_ctrl_ch1 <= next_io_ctrl_ch1;
         io_ctrl_ch2 <= next_io_ctrl_ch2;
      end
   end

   // -----------------------------------------------------------------
   // mode registers
   // -----------------------------------------------------------------
   logic [DATA_W-1:0] mode_ch0;
   logic [DATA_W-1:0] mode_ch1;
   logic [DATA_W-1:0] mode_ch2;
   logic [DATA_W-1:0] next_mode_ch0;
   logic [DATA_W-1:0] next_mode_ch1;
   logic [DATA_W-1:0] next_mode_ch2;

   // modes are stored with MODE_FIXED_ONES forced on; the buffer bits are
   // cleared for channels 1 and 2, which have no C and D registers
   always_comb begin
      next_mode_ch0 = mode_ch0;
      next_mode_ch1 = mode_ch1;
      next_mode_ch2 = mode_ch2;
      if (hit(i_wr, i_addr, ADDR_MODE_CH0)) begin
         next_mode_ch0 = mode_value(i_wdata, 1'b1);
      end
      if (hit(i_wr, i_addr, ADDR_MODE_CH1)) begin
         next_mode_ch1 = mode_value(i_wdata, 1'b0);
      end
      if (hit(i_wr, i_addr, ADDR_MODE_CH2)) begin
         next_mode_ch2 = mode_value(i_wdata, 1'b0);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         mode_ch0 <= MODE_FIXED_ONES;
         mode_ch1 <= MODE_FIXED_ONES;
         mode_ch2 <= MODE_FIXED_ONES;
      end else begin
         mode_ch0 <= next_mode_ch0;
         mode_ch1 <= next_mode_ch1;
         mode_ch2 <= next_mode_ch2;
      end
   end

   // -----------------------------------------------------------------
   // counter run bits
   // -----------------------------------------------------------------
   logic [NUM_CH-1:0] run;
   logic [NUM_CH-1:0] next_run;

   always_comb begin
      next_run = run;
      if (hit(i_wr, i_addr, ADDR_RUN)) begin
         next_run = i_wdata[NUM_CH-1:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         run <= '0;
      end else begin
         run <= next_run;
      end
   end

   assign o_run = run;

   // -----------------------------------------------------------------
   // read data, standing only in the cycle after the read strobe
   // -----------------------------------------------------------------
   logic [DATA_W-1:0] rdata;
   logic [DATA_W-1:0] next_rdata;

   always_comb begin
      next_rdata = DATA_ZERO;
      if (i_rd) begin
         unique case (i_addr)
            ADDR_IO_CH0_HIGH: next_rdata = io_ctrl_ch0_high;
            ADDR_IO_CH0_LOW: next_rdata = io_ctrl_ch0_low;
            ADDR_IO_CH1: next_rdata = io_ctrl_ch1;
            ADDR_IO_CH2: next_rdata = io_ctrl_ch2;
            ADDR_MODE_CH0: next_rdata = mode_ch0;
            ADDR_MODE_CH1: next_rdata = mode_ch1;
            ADDR_MODE_CH2: next_rdata = mode_ch2;
            ADDR_RUN: next_rdata = {{(DATA_W-NUM_CH){1'b0}}, run};
            default: next_rdata = DATA_ZERO;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         rdata <= DATA_ZERO;
      end else begin
         rdata <= next_rdata;
      end
   end

   assign o_rdata = rdata;

   // -----------------------------------------------------------------
   // field routing
   // -----------------------------------------------------------------
   logic [FIELD_W-1:0] field [NUM_GR];
   logic [NUM_CH-1:0] pwm2;
   logic [NUM_GR-1:0] buffered;

   assign field[GR_A0] = io_ctrl_ch0_high[FIELD_W-1:0];
   assign field[GR_B0] = io_ctrl_ch0_high[DATA_W-1:FIELD_HI_LSB];
   assign field[GR_C0] = io_ctrl_ch0_low[FIELD_W-1:0];
   assign field[GR_D0] = io_ctrl_ch0_low[DATA_W-1:FIELD_HI_LSB];
   assign field[GR_A1] = io_ctrl_ch1[FIELD_W-1:0];
   assign field[GR_B1] = io_ctrl_ch1[DATA_W-1:FIELD_HI_LSB];
   assign field[GR_A2] = io_ctrl_ch2[FIELD_W-1:0];
   assign field[GR_B2] = io_ctrl_ch2[DATA_W-1:FIELD_HI_LSB];

   assign pwm2[0] = (mode_ch0[FIELD_W-1:0] == MODE_PWM2);
   assign pwm2[1] = (mode_ch1[FIELD_W-1:0] == MODE_PWM2);
   assign pwm2[2] = (mode_ch2[FIELD_W-1:0] == MODE_PWM2);

   // only C and D of channel 0 can be turned into buffers
   always_comb begin
      buffered = '0;
      buffered[GR_C0] = mode_ch0[BFA_BIT];
      buffered[GR_D0] = mode_ch0[BFB_BIT];
   end

   // -----------------------------------------------------------------
   // per general register pin logic
   // -----------------------------------------------------------------
   for (genvar g = 0; g < NUM_GR; g++) begin : g_gr
      localparam int CH = gr_chan(g);
      io_decode_s dec;
      logic active;
      pin_drive_s drv;
      pin_drive_s next_drv;
      logic sync1;
      logic sync2;
      logic prev;
      logic next_sync1;
      logic next_sync2;
      logic next_prev;
      logic cap;
      logic next_cap;
      logic rise;
      logic fall;

      assign dec = decode_io(field[g]);
      // a buffer register makes neither compare nor capture events
      assign active = ~buffered[g];
      assign rise = sync2 & ~prev;
      assign fall = ~sync2 & prev;

      // compare output level and enable
      always_comb begin
         next_drv.level = drv.level;
         next_drv.oe = dec.out_en & active;
         if (active && dec.compare && dec.out_en) begin
            if (!run[CH]) begin
               next_drv.level = dec.init_level;
            end else if (pwm2[CH] && i_ctr_clear[CH]) begin
               next_drv.level = dec.init_level;
            end else if (i_cmp_match[g]) begin
               unique case (dec.action)
                  ACT_LOW: next_drv.level = 1'b0;
                  ACT_HIGH: next_drv.level = 1'b1;
                  ACT_TOGGLE: next_drv.level = ~drv.level;
                  default: next_drv.level = drv.level;
               endcase
            end
         end
      end

      always_ff @(posedge i_clk) begin
         if (i_srst) begin
            drv <= '0;
         end else begin
            drv <= next_drv;
         end
      end

      // two-stage pin synchroniser, then the previous sample for edges
      always_comb begin
         next_sync1 = i_pin[g];
         next_sync2 = sync1;
         next_prev = sync2;
      end

      always_ff @(posedge i_clk) begin
         if (i_srst) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            prev <= 1'b0;
         end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            prev <= next_prev;
         end
      end

      // capture event, one cycle per qualifying edge
      always_comb begin
         next_cap = 1'b0;
         if (active && dec.capture) begin
            unique case (dec.action)
               CAP_RISE: next_cap = rise;
               CAP_FALL: next_cap = fall;
               default: next_cap = rise | fall;
            endcase
         end
      end

      always_ff @(posedge i_clk) begin
         if (i_srst) begin
            cap <= 1'b0;
         end else begin
            cap <= next_cap;
         end
      end

      assign o_pin[g] = drv.level;
      assign o_pin_oe[g] = drv.oe;
      assign o_capture[g] = cap;
   end

endmodule // timer_io_control

// ==== tio_pkg.sv ====
// constants, field layouts and decode helpers for the timer I/O control block
// assumes one 100 MHz peripheral clock and a plain 8-bit register port
package tio_pkg;

   // -----------------------------------------------------------------
   // sizes
   // -----------------------------------------------------------------
   localparam int NUM_GR = 8;
   localparam int NUM_CH = 3;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // -----------------------------------------------------------------
   // register offsets
   // -----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_IO_CH0_HIGH = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_IO_CH0_LOW = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_IO_CH1 = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_IO_CH2 = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_MODE_CH0 = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_MODE_CH1 = 4'h5;
   localparam logic [ADDR_W-1:0] ADDR_MODE_CH2 = 4'h6;
   localparam logic [ADDR_W-1:0] ADDR_RUN = 4'h7;

   // -----------------------------------------------------------------
   // reset values and field positions
   // -----------------------------------------------------------------
   localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
   localparam logic [DATA_W-1:0] MODE_FIXED_ONES = 8'hC0;
   localparam int BFB_BIT = 5;
   localparam int BFA_BIT = 4;
   localparam int FIELD_W = 4;
   localparam int FIELD_HI_LSB = 4;
   localparam logic [3:0] MODE_PWM2 = 4'h3;
   localparam logic [1:0] MODE_BUF_NONE = 2'h0;

   // general register index: channel 0 A..D, channel 1 A,B, channel 2 A,B
   localparam int GR_A0 = 0;
   localparam int GR_B0 = 1;
   localparam int GR_C0 = 2;
   localparam int GR_D0 = 3;
   localparam int GR_A1 = 4;
   localparam int GR_B1 = 5;
   localparam int GR_A2 = 6;
   localparam int GR_B2 = 7;

   // -----------------------------------------------------------------
   // io field codes
   // -----------------------------------------------------------------
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_LOW = 2'h1;
   localparam logic [1:0] ACT_HIGH = 2'h2;
   localparam logic [1:0] ACT_TOGGLE = 2'h3;
   localparam logic [1:0] CAP_RISE = 2'h0;
   localparam logic [1:0] CAP_FALL = 2'h1;
   localparam logic [1:0] KIND_CAPTURE = 2'h2;

   typedef struct packed {
      logic compare;
      logic capture;
      logic out_en;
      logic init_level;
      logic [1:0] action;
   } io_decode_s;

   typedef struct packed {
      logic level;
      logic oe;
   } pin_drive_s;

   // top bit 0: compare; top bits 10: capture; 11xx prohibited, no function
   function automatic io_decode_s decode_io(input logic [FIELD_W-1:0] f);
      io_decode_s d;
      d.compare = ~f[3];
      d.capture = (f[3:2] == KIND_CAPTURE);
      d.out_en = ~f[3] & (f[1:0] != ACT_NONE);
      d.init_level = f[2];
      d.action = f[1:0];
      return d;
   endfunction

   function automatic int gr_chan(input int g);
      return (g < GR_A1) ? 0 : ((g < GR_A2) ? 1 : 2);
   endfunction

endpackage

// ==== timer_io_control_checker.sv ====
// concurrent checks on the ports of timer_io_control
// assumes the bench holds each pin level at least two cycles
module timer_io_control_checker
   import tio_pkg::*;
(
   input wire logic i_clk, // clock
   input wire logic i_srst, // reset
   input wire logic [ADDR_W-1:0] i_addr, // address
   input wire logic [DATA_W-1:0] i_wdata, // write data
   input wire logic i_wr, // write strobe
   input wire logic i_rd, // read strobe
   input wire logic [DATA_W-1:0] o_rdata, // read data
   input wire logic [NUM_GR-1:0] i_cmp_match, // compare match
   input wire logic [NUM_CH-1:0] i_ctr_clear, // counter clear
   input wire logic [NUM_CH-1:0] o_run, // run bits
   input wire logic [NUM_GR-1:0] o_capture, // capture pulses
   input wire logic [NUM_GR-1:0] i_pin, // pin levels
   input wire logic [NUM_GR-1:0] o_pin, // pin drive
   input wire logic [NUM_GR-1:0] o_pin_oe // pin enables
);
   // ------------
   // properties
   // ------------
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (i_srst);
   sequence s_io_write;
      i_wr && i_addr < ADDR_MODE_CH0;
   endsequence
   sequence s_same_read;
      !i_wr ##1 i_rd && i_addr == $past(i_addr, 2);
   endsequence
   property p_readback;
      s_io_write ##1 s_same_read |=> o_rdata == $past(i_wdata, 3);
   endproperty
   a_readback: assert property (p_readback) else $error("readback");
   property p_rdata_idle;
      !$past(i_rd) |-> o_rdata == DATA_ZERO;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("idle");
   property p_unmapped;
      i_rd && i_addr > ADDR_RUN |=> o_rdata == DATA_ZERO;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped");
   property p_mode_bits;
      i_rd && (i_addr == ADDR_MODE_CH1 || i_addr == ADDR_MODE_CH2)
         |=> o_rdata[7:4] == 4'hC;
   endproperty
   a_mode_bits: assert property (p_mode_bits) else $error("mode");
   property p_run_write;
      i_wr && i_addr == ADDR_RUN |=> o_run == NUM_CH'($past(i_wdata));
   endproperty
   a_run_write: assert property (p_run_write) else $error("run");
   property p_pin_hold;
      !i_wr && !$past(i_wr) && o_run == '1 && $past(o_run) == '1
         && i_cmp_match == '0 && i_ctr_clear == '0 |=> $stable(o_pin);
   endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("pin hold");
   property p_cap_once;
      (o_capture & $past(o_capture)) == '0;
   endproperty
   a_cap_once: assert property (p_cap_once) else $error("cap twice");
   property p_cap_cause;
      (o_capture & ~(($past(i_pin, 2) ^ $past(i_pin, 4))
         | ($past(i_pin, 3) ^ $past(i_pin, 5)))) == '0;
   endproperty
   a_cap_cause: assert property (p_cap_cause) else $error("cap");
endmodule // timer_io_control_checker

bind timer_io_control timer_io_control_checker u_chk (
   .i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cmp_match(i_cmp_match),
   .i_ctr_clear(i_ctr_clear), .o_run(o_run), .o_capture(o_capture),
   .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe(o_pin_oe)
);

// ==== tio_pin_model.sv ====
// far-side pin model: resolves each timer pin from both drivers
// assumes the bench supplies the external source level per pin
module tio_pin_model
   import tio_pkg::*;
(
   input wire logic [NUM_GR-1:0] i_ext, // external source levels
   input wire logic [NUM_GR-1:0] i_pin, // block drive levels
   input wire logic [NUM_GR-1:0] i_pin_oe, // block drive enables
   output logic [NUM_GR-1:0] o_wire // resolved pin levels
);
   // block wins where enabled; each register has its own line
   assign o_wire = (i_pin_oe & i_pin) | (~i_pin_oe & i_ext);
endmodule // tio_pin_model

// ==== tb_timer_io_control.sv ====
// bench for timer_io_control: register, compare and capture checks
// assumes tio_pin_model closes the pins and the checker is bound
module tb_timer_io_control
   import tio_pkg::*;
   ();
   timeunit 1ns;
   timeprecision 1ns;
   // ------------
   // signals
   // ------------
   logic i_clk = 0, i_srst = 1, i_wr = 0, i_rd = 0;
   logic [ADDR_W-1:0] i_addr = '0;
   logic [DATA_W-1:0] i_wdata = '0, o_rdata;
   logic [NUM_GR-1:0] cmp = '0, ext = '0, pin, o_pin, oe, cap;
   logic [NUM_CH-1:0] clr = '0, run;
   logic [DATA_W-1:0] io_val [4] = '{8'h35, 8'hA3, 8'hC9, 8'hA8};
   int mismatches = 0, samples_checked = 0;
   timer_io_control dut (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_cmp_match(cmp), .i_ctr_clear(clr), .o_run(run), .o_capture(cap),
      .i_pin(pin), .o_pin(o_pin), .o_pin_oe(oe));
   tio_pin_model pins (.i_ext(ext), .i_pin(o_pin), .i_pin_oe(oe),
      .o_wire(pin));
   initial forever #5 i_clk = ~i_clk;
   // ------------
   // tasks
   // ------------
   task automatic chk(input string what, input logic [DATA_W-1:0] e,
      input logic [DATA_W-1:0] got);
      samples_checked++;
      if (got !== e) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", what, e, got);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      chk("rdata", e, o_rdata);
   endtask
   task automatic pulse(input logic [NUM_GR-1:0] m,
      input logic [NUM_CH-1:0] c, input logic [DATA_W-1:0] e);
      @(posedge i_clk);
      cmp <= m;
      clr <= c;
      @(posedge i_clk);
      cmp <= '0;
      clr <= '0;
      #1;
      chk("pin", e, o_pin & oe);
   endtask
   task automatic edges(input logic [NUM_GR-1:0] lv,
      input logic [DATA_W-1:0] e);
      logic [NUM_GR-1:0] seen;
      seen = '0;
      @(posedge i_clk);
      ext <= lv;
      repeat (8) begin
         @(posedge i_clk);
         #1;
         seen |= cap;
      end
      chk("capture", e, seen);
   endtask
   task automatic summarize();
      $display("mismatches %0d samples_checked %0d", mismatches,
         samples_checked);
      if (mismatches == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge i_clk);
      mismatches++;
      summarize();
   end
   initial begin
      repeat (20) @(posedge i_clk);
      i_srst <= 1'b0;
      for (int a = 0; a < 4; a++) rd(ADDR_W'(a), REG_RESET);
      rd(ADDR_MODE_CH0, MODE_FIXED_ONES);
      rd(4'hF, DATA_ZERO);
      wr(ADDR_MODE_CH1, 8'h37);
      rd(ADDR_MODE_CH1, 8'hC7);
      wr(ADDR_MODE_CH1, DATA_ZERO);
      for (int a = 0; a < 4; a++) begin
         wr(ADDR_W'(a), io_val[a]);
         rd(ADDR_W'(a), io_val[a]);
      end
      @(posedge i_clk);
      #1;
      chk("oe", 8'h07, oe);
      chk("pin", 8'h01, o_pin & oe);
      edges(8'hFF, 8'hC8);
      edges(8'h00, 8'h98);
      wr(ADDR_RUN, 8'h07);
      #1;
      chk("run", 8'h07, DATA_W'(run));
      pulse(8'h07, 3'h0, 8'h06);
      pulse(8'h02, 3'h0, 8'h04);
      wr(ADDR_RUN, DATA_ZERO);
      wr(ADDR_MODE_CH0, 8'h33);
      rd(ADDR_MODE_CH0, 8'hF3);
      chk("oe", 8'h03, oe);
      chk("pin", 8'h01, o_pin & oe);
      edges(8'hFF, 8'hC0);
      wr(ADDR_RUN, 8'h07);
      pulse(8'h01, 3'h0, 8'h00);
      pulse(8'h01, 3'h1, 8'h01);
      summarize();
   end
endmodule // tb_timer_io_control
